/* File: hdl/iopm_pkg.sv */
// Constants shared by the port mode select block and its pin slice.
// Assumes an APB master with 32-bit data and byte addresses.
package iopm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Port geometry
  localparam int NUM_PORTS = 7;
  localparam int PORT_W = 8;
  localparam int ADDR_W = 16;
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PORT_E = 4;
  localparam int PORT_F = 5;
  localparam int PORT_G = 6;
  localparam int NUM_IMC_PORTS = 3;
  localparam logic [7:0] PORT_D_MASK = 8'h0f;
  localparam logic [7:0] JTAG_PIN_MASK = 8'h0f;

  ////////////////////////////////////////////////////////////////////////////
  // Register map: one 16-byte group per port, index in paddr[6:4]
  localparam int APB_AW = 8;
  localparam int PORT_IDX_LSB = 4;
  localparam int PORT_IDX_MSB = 6;
  localparam int REG_SEL_LSB = 2;
  localparam int REG_SEL_MSB = 3;
  localparam logic [1:0] REG_DATA_IN = 2'h0;
  localparam logic [1:0] REG_DATA_OUT = 2'h1;
  localparam logic [1:0] REG_DIRECTION = 2'h2;
  localparam logic [1:0] REG_MODE_CTRL = 2'h3;
  localparam logic [7:0] OFS_MEMORY_MAPPING_CONTROL = 8'h70;
  localparam logic [7:0] OFS_LATCHED_ADDR = 8'h74;
  localparam logic [7:0] OFS_IMC_AB = 8'h78;
  localparam logic [7:0] OFS_IMC_C = 8'h7c;
  localparam logic [2:0] LAST_PORT_IDX = 3'h6;
  localparam int PERIPHERAL_BUFFER_BIT = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] OE_N_RESET = 8'hff;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

endpackage : iopm_pkg

/* File: hdl/iopm_port.sv */
// One 8-pin port: pin synchroniser, output source mux and driver enable.
// Assumes all control inputs are on ref_clk; pinIn comes from the pads.
`timescale 1ns/1ps
module iopm_port #(
  parameter logic HAS_OE_TERM = 1'b0
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] pinIn,
  input wire logic [7:0] dataOut,
  input wire logic [7:0] direction,
  input wire logic [7:0] modeCtrl,
  input wire logic [7:0] addrCapable,
  input wire logic [7:0] addrByte,
  input wire logic [7:0] logicArraySel,
  input wire logic [7:0] macrocellOut,
  input wire logic [7:0] macrocellOe,
  input wire logic [7:0] altEn,
  input wire logic [7:0] altData,
  input wire logic altOe,
  output logic [7:0] pinOut,
  output logic [7:0] pinOeN,
  output logic [7:0] pinLevel
);

  logic [7:0] syncMeta;
  logic [7:0] oeTerm;
  logic [7:0] drive;
  logic [7:0] addrMode;
  logic [7:0] next_pinOut;
  logic [7:0] next_pinOeN;

  ////////////////////////////////////////////////////////////////////////////
  // Pad input: two flops before any logic
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncMeta <= iopm_pkg::REG_RESET;
      pinLevel <= iopm_pkg::REG_RESET;
    end else begin
      syncMeta <= pinIn;
      pinLevel <= syncMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output select
  always_comb begin
    // Only some ports carry the array enable term into the driver
    oeTerm = HAS_OE_TERM ? (logicArraySel & macrocellOe) : 8'h00;
    drive = direction | oeTerm;
    addrMode = modeCtrl & addrCapable;
    next_pinOut = (addrMode & drive & addrByte)
      | (~addrMode & logicArraySel & macrocellOut)
      | (~addrMode & ~logicArraySel & dataOut);
    next_pinOeN = ~drive;
    next_pinOut = (altEn & altData) | (~altEn & next_pinOut);
    next_pinOeN = (altEn & {8{~altOe}}) | (~altEn & next_pinOeN);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinOut <= iopm_pkg::REG_RESET;
      pinOeN <= iopm_pkg::OE_N_RESET;
    end else begin
      pinOut <= next_pinOut;
      pinOeN <= next_pinOeN;
    end
  end

endmodule : iopm_port

/* File: hdl/io_port_mode_select.sv */
// Port mode select for ports A to G with APB register access.
// Assumes static configuration inputs held stable, logic-array signals on
// ref_clk, and host address and latch strobe arriving from pins.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Function
// - Configuration-fixed modes come from inputs only
// - Other modes change by register writes anytime
// - Zero mode bit on E,F,G gives processor I/O
// - A,B,C,F drive when direction or enable term
// - Output pin driven from data out register
// - Input pin level readable through data in
// - Ports A,B,C have no mode bits
// - Array output tri-states without enable or direction
// - Address out when enable or direction and mode
// - Address out on E,F,G; data/peripheral on F
// - Port F is data port for non-multiplexed bus
// - Test pins only on port E, three enables
// - Address byte mapping; non-multiplexed only port G
// - Mode bit one selects address output, default I/O
// - Peripheral buffer enabled by top mapping bit
// - Address inputs latched on address latch strobe
module io_port_mode_select (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [6:0][7:0] portPinIn,
  output logic [6:0][7:0] portPinOut,
  output logic [6:0][7:0] portPinOeN,
  input wire logic [6:0][7:0] cfgLogicArray,
  input wire logic [6:0][7:0] macrocellOut,
  input wire logic [6:0][7:0] macrocellOe,
  input wire logic cfgMuxBus,
  input wire logic cfgPortGHigh,
  input wire logic [2:0] jtagEnable,
  input wire logic [15:0] hostAddr,
  input wire logic addressLatchStrobe,
  input wire logic [7:0] busWrData,
  input wire logic busDrive,
  input wire logic busWrite,
  input wire logic peripheralSelectA,
  input wire logic peripheralSelectB,
  output logic [7:0] portFBusData,
  output logic [2:0][7:0] inputMacrocell,
  output logic [15:0] latchedAddr
);

  logic [6:0][7:0] dataOutReg;
  logic [6:0][7:0] directionReg;
  logic [6:0][7:0] modeCtrlReg;
  logic memoryMappingControl;
  logic [6:0][7:0] next_dataOutReg;
  logic [6:0][7:0] next_directionReg;
  logic [6:0][7:0] next_modeCtrlReg;
  logic next_memoryMappingControl;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [6:0][7:0] pinLevel;
  logic [6:0][7:0] addrCapable;
  logic [6:0][7:0] addrByte;
  logic [6:0][7:0] altEn;
  logic [6:0][7:0] altData;
  logic [6:0] altOe;
  logic [15:0] addrMeta;
  logic [15:0] addrSync;
  logic strobeMeta;
  logic strobeSync;
  logic strobeLast;
  logic strobeFall;
  logic [15:0] next_latchedAddr;
  logic [2:0][7:0] next_inputMacrocell;
  logic jtagOn;
  logic periphMode;
  logic periphActive;
  logic [2:0] portIdx;
  logic [1:0] regSel;
  logic accessPhase;
  logic portHit;
  logic hasModeCtrl;
  logic [7:0] portMask;

  ////////////////////////////////////////////////////////////////////////////
  // Host address pins and strobe: two flops first
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addrMeta <= iopm_pkg::ADDR_RESET;
      addrSync <= iopm_pkg::ADDR_RESET;
      strobeMeta <= 1'b0;
      strobeSync <= 1'b0;
      strobeLast <= 1'b0;
    end else begin
      addrMeta <= hostAddr;
      addrSync <= addrMeta;
      strobeMeta <= addressLatchStrobe;
      strobeSync <= strobeMeta;
      strobeLast <= strobeSync;
    end
  end

  // Address is stable while the strobe is high; capture on its fall
  assign strobeFall = strobeLast & ~strobeSync;

  always_comb begin
    next_latchedAddr = latchedAddr;
    next_inputMacrocell = inputMacrocell;
    if (strobeFall) begin
      next_latchedAddr = addrSync;
      for (int p = 0; p < iopm_pkg::NUM_IMC_PORTS; p++) begin
        next_inputMacrocell[p] = pinLevel[p];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      latchedAddr <= iopm_pkg::ADDR_RESET;
      inputMacrocell <= '0;
    end else begin
      latchedAddr <= next_latchedAddr;
      inputMacrocell <= next_inputMacrocell;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode routing from static configuration and the memoryMappingControl bit
  assign jtagOn = |jtagEnable;
  assign periphMode = memoryMappingControl;
  assign periphActive = peripheralSelectA | peripheralSelectB;

  always_comb begin
    addrCapable = '0;
    addrByte = '0;
    altEn = '0;
    altData = '0;
    altOe = '0;
    // Non-multiplexed hosts lose address out on E and F
    addrCapable[iopm_pkg::PORT_E] = {8{cfgMuxBus}};
    addrCapable[iopm_pkg::PORT_F] = {8{cfgMuxBus}};
    addrCapable[iopm_pkg::PORT_G] = 8'hff;
    addrByte[iopm_pkg::PORT_E] = latchedAddr[7:0];
    addrByte[iopm_pkg::PORT_F] = latchedAddr[7:0];
    // High byte on port G only makes sense for multiplexed hosts
    addrByte[iopm_pkg::PORT_G] = (cfgPortGHigh & cfgMuxBus) ? latchedAddr[15:8] : latchedAddr[7:0];
    // Test pins released from port logic while enabled
    altEn[iopm_pkg::PORT_E] = {8{jtagOn}} & iopm_pkg::JTAG_PIN_MASK;
    if (!cfgMuxBus) begin
      altEn[iopm_pkg::PORT_F] = 8'hff;
      altData[iopm_pkg::PORT_F] = busWrData;
      altOe[iopm_pkg::PORT_F] = busDrive;
    end else if (periphMode) begin
      altEn[iopm_pkg::PORT_F] = 8'hff;
      altData[iopm_pkg::PORT_F] = busWrData;
      altOe[iopm_pkg::PORT_F] = periphActive & busWrite;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin slices
  genvar gp;
  generate
    for (gp = 0; gp < iopm_pkg::NUM_PORTS; gp++) begin : g_port
      localparam logic OE_TERM = (gp == iopm_pkg::PORT_A) || (gp == iopm_pkg::PORT_B)
        || (gp == iopm_pkg::PORT_C) || (gp == iopm_pkg::PORT_F);
      iopm_port #(
        .HAS_OE_TERM(OE_TERM)
      ) u_port (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pinIn(portPinIn[gp]),
        .dataOut(dataOutReg[gp]),
        .direction(directionReg[gp]),
        .modeCtrl(modeCtrlReg[gp]),
        .addrCapable(addrCapable[gp]),
        .addrByte(addrByte[gp]),
        .logicArraySel(cfgLogicArray[gp]),
        .macrocellOut(macrocellOut[gp]),
        .macrocellOe(macrocellOe[gp]),
        .altEn(altEn[gp]),
        .altData(altData[gp]),
        .altOe(altOe[gp]),
        .pinOut(portPinOut[gp]),
        .pinOeN(portPinOeN[gp]),
        .pinLevel(pinLevel[gp])
      );
    end
  endgenerate

  assign portFBusData = pinLevel[iopm_pkg::PORT_F];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign portIdx = paddr[iopm_pkg::PORT_IDX_MSB:iopm_pkg::PORT_IDX_LSB];
  assign regSel = paddr[iopm_pkg::REG_SEL_MSB:iopm_pkg::REG_SEL_LSB];
  // One wait state: pready rises on the second access cycle
  assign accessPhase = psel & penable & ~pready;
  assign portHit = (paddr[7] == 1'b0) && (portIdx <= iopm_pkg::LAST_PORT_IDX)
    && (paddr[1:0] == 2'b00);
  assign hasModeCtrl = (portIdx == 3'(iopm_pkg::PORT_E)) || (portIdx == 3'(iopm_pkg::PORT_F))
    || (portIdx == 3'(iopm_pkg::PORT_G));
  assign portMask = (portIdx == 3'(iopm_pkg::PORT_D)) ? iopm_pkg::PORT_D_MASK : 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_comb begin
    next_dataOutReg = dataOutReg;
    next_directionReg = directionReg;
    next_modeCtrlReg = modeCtrlReg;
    next_memoryMappingControl = memoryMappingControl;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (accessPhase) begin
      next_pready = 1'b1;
      next_prdata = iopm_pkg::RDATA_RESET;
      if (portHit) begin
        case (regSel)
          iopm_pkg::REG_DATA_IN: begin
            next_prdata[7:0] = pinLevel[portIdx] & portMask;
          end
          iopm_pkg::REG_DATA_OUT: begin
            next_prdata[7:0] = dataOutReg[portIdx];
            if (pwrite) begin
              next_dataOutReg[portIdx] = pwdata[7:0] & portMask;
            end
          end
          iopm_pkg::REG_DIRECTION: begin
            next_prdata[7:0] = directionReg[portIdx];
            if (pwrite) begin
              next_directionReg[portIdx] = pwdata[7:0] & portMask;
            end
          end
          iopm_pkg::REG_MODE_CTRL: begin
            next_prdata[7:0] = modeCtrlReg[portIdx];
            if (pwrite && hasModeCtrl) begin
              next_modeCtrlReg[portIdx] = pwdata[7:0];
            end
          end
          default: begin
            next_pslverr = 1'b1;
          end
        endcase
      end else begin
        case (paddr)
          iopm_pkg::OFS_MEMORY_MAPPING_CONTROL: begin
            next_prdata[iopm_pkg::PERIPHERAL_BUFFER_BIT] = memoryMappingControl;
            if (pwrite) begin
              next_memoryMappingControl = pwdata[iopm_pkg::PERIPHERAL_BUFFER_BIT];
            end
          end
          iopm_pkg::OFS_LATCHED_ADDR: begin
            next_prdata[15:0] = latchedAddr;
          end
          iopm_pkg::OFS_IMC_AB: begin
            next_prdata[15:0] = {inputMacrocell[iopm_pkg::PORT_B], inputMacrocell[iopm_pkg::PORT_A]};
          end
          iopm_pkg::OFS_IMC_C: begin
            next_prdata[7:0] = inputMacrocell[iopm_pkg::PORT_C];
          end
          default: begin
            next_pslverr = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataOutReg <= '0;
      directionReg <= '0;
      modeCtrlReg <= '0;
      memoryMappingControl <= 1'b0;
      prdata <= iopm_pkg::RDATA_RESET;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      dataOutReg <= next_dataOutReg;
      directionReg <= next_directionReg;
      modeCtrlReg <= next_modeCtrlReg;
      memoryMappingControl <= next_memoryMappingControl;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule : io_port_mode_select

/* File: verif/iopm_checker.sv */
// Checker for the port mode select: APB handshake and pin drive relations.
// Assumes it is bound onto io_port_mode_select and sees its ports only.
`timescale 1ns/1ps
module iopm_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [6:0][7:0] portPinOut,
  input wire logic [6:0][7:0] portPinOeN,
  input wire logic [6:0][7:0] cfgLogicArray,
  input wire logic cfgMuxBus,
  input wire logic [2:0] jtagEnable,
  input wire logic [7:0] busWrData,
  input wire logic busDrive
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_done; psel && penable && pready; endsequence
  property p_oneWait; s_wait |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_errAlign; s_wait ##0 paddr[1:0] != 2'h0 |=> pslverr; endproperty
  property p_errOk; s_wait ##0 paddr == 8'h08 |=> !pslverr; endproperty
  // Register landed before s_done; the pad driver follows on the next edge, checked one edge later
  property p_dirWrite;
    s_done ##0 (pwrite && paddr == 8'h08 && cfgLogicArray[0] == 8'h00) |=> ##1 portPinOeN[0] == ~$past(pwdata[7:0], 2);
  endproperty
  property p_jtag; |jtagEnable ##1 |jtagEnable |-> portPinOeN[4][3:0] == 4'hf; endproperty
  property p_dataPort;
    !cfgMuxBus && busDrive |=> portPinOeN[5] == 8'h00 && portPinOut[5] == $past(busWrData);
  endproperty
  property p_dataFloat; !cfgMuxBus && !busDrive |=> portPinOeN[5] == 8'hff; endproperty
  property p_hold; !psel |=> $stable(prdata); endproperty
  a_oneWait: assert property (p_oneWait) else $error("pready late");
  a_pulse: assert property (p_pulse) else $error("pready too long");
  a_errAlign: assert property (p_errAlign) else $error("no error on unaligned");
  a_errOk: assert property (p_errOk) else $error("error on mapped");
  a_dirWrite: assert property (p_dirWrite) else $error("direction not on pins");
  a_jtag: assert property (p_jtag) else $error("test pins driven");
  a_dataPort: assert property (p_dataPort) else $error("data port not driven");
  a_dataFloat: assert property (p_dataFloat) else $error("data port not floating");
  a_hold: assert property (p_hold) else $error("prdata moved");
endmodule : iopm_checker

bind io_port_mode_select iopm_checker u_iopm_checker (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .portPinOut, .portPinOeN, .cfgLogicArray, .cfgMuxBus, .jtagEnable,
  .busWrData, .busDrive);

/* File: verif/iopm_host_model.sv */
// Host side model: pad wires and the multiplexed address phase.
// Assumes the bench supplies outside pad levels and calls latch.
`timescale 1ns/1ps
module iopm_host_model (
  input wire logic ref_clk,
  input wire logic [6:0][7:0] portPinOut,
  input wire logic [6:0][7:0] portPinOeN,
  input wire logic [6:0][7:0] extLevel,
  output logic [6:0][7:0] portPinIn,
  output logic [15:0] hostAddr,
  output logic addressLatchStrobe
);
  // Pad level: device drive wins, else the outside level
  always_comb begin
    for (int p = 0; p < 7; p++) portPinIn[p] = (portPinOut[p] & ~portPinOeN[p]) | (extLevel[p] & portPinOeN[p]);
  end
  initial begin
    hostAddr = 16'h0000;
    addressLatchStrobe = 1'b0;
  end
  // Called only after direction and mode are set up
  task automatic latch(input logic [15:0] a);
    hostAddr <= a;
    addressLatchStrobe <= 1'b1;
    repeat (4) @(posedge ref_clk);
    addressLatchStrobe <= 1'b0;
    repeat (6) @(posedge ref_clk);
    // Bus turns to data: address no longer valid
    hostAddr <= ~a;
  endtask : latch
endmodule : iopm_host_model

/* File: verif/tb_top.sv */
// Bench for the port mode select: APB tests with expected pin values.
// Assumes the host model closes the pad loop and the checker is bound.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, busWrData, portFBusData;
  logic [31:0] pwdata, prdata, r;
  logic [6:0][7:0] portPinIn, portPinOut, portPinOeN, cfgLogicArray, macrocellOut, macrocellOe, extLevel;
  logic cfgMuxBus, cfgPortGHigh, addressLatchStrobe, busDrive, busWrite, peripheralSelectA, peripheralSelectB;
  logic [2:0] jtagEnable;
  logic [15:0] hostAddr, latchedAddr;
  logic [2:0][7:0] inputMacrocell;
  int num_errors = 0;
  int cmp_count = 0;
  io_port_mode_select u_io_port_mode_select (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .portPinIn, .portPinOut, .portPinOeN, .cfgLogicArray, .macrocellOut,
    .macrocellOe, .cfgMuxBus, .cfgPortGHigh, .jtagEnable, .hostAddr, .addressLatchStrobe, .busWrData,
    .busDrive, .busWrite, .peripheralSelectA, .peripheralSelectB, .portFBusData, .inputMacrocell, .latchedAddr);
  iopm_host_model u_iopm_host_model (.ref_clk, .portPinOut, .portPinOeN, .extLevel, .portPinIn, .hostAddr,
    .addressLatchStrobe);
  ////////////////////////////////////////
  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    cmp_count++;
    if (g !== x) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
      num_errors++;
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // One transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) num_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(64'(r), 64'(x));
  endtask : rd
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    summarize();
  end
  initial begin
    {sys_rst, cfgMuxBus} = 2'h3;
    {psel, penable, pwrite, cfgPortGHigh, busDrive, busWrite, peripheralSelectA, peripheralSelectB} = 8'h00;
    {paddr, pwdata, jtagEnable, busWrData} = {8'h00, 32'h0, 3'h0, 8'h5a};
    {cfgLogicArray, macrocellOut, macrocellOe} = '0;
    extLevel = {7{8'h96}};
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    for (int p = 0; p < 7; p++) for (int k = 1; k < 4; k++) rd(8'(p * 16 + k * 4), 32'h0);
    chk(64'(portPinOeN), {8'h0, {56{1'b1}}});
    $display("test reset done");
    wr(8'h08, 8'h0f);
    wr(8'h04, 8'ha5);
    chk(64'({portPinOeN[0], portPinOut[0] & 8'h0f}), 64'h0000f005);
    repeat (2) @(posedge ref_clk);
    rd(8'h00, 32'h95);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 32'h0);
    wr(8'h08, 8'h00);
    apb(1'b0, 8'h09, 32'h0);
    chk(64'(e), 64'h1);
    $display("test port a done");
    cfgPortGHigh <= 1'b1;
    for (int k = 0; k < 4; k++) wr(8'(k < 2 ? 8'h48 + k * 4 : 8'h60 + k * 4), 8'hff);
    u_iopm_host_model.latch(16'hc3a5);
    chk(64'({portPinOut[4], portPinOut[6]}), 64'ha5c3);
    chk(64'({latchedAddr, inputMacrocell}), 64'hc3a5969696);
    rd(8'h74, 32'hc3a5);
    rd(8'h78, 32'h9696);
    rd(8'h7c, 32'h96);
    rd(8'h4c, 32'hff);
    wr(8'h4c, 8'h00);
    wr(8'h44, 8'h3c);
    chk(64'(portPinOut[4]), 64'h3c);
    $display("test address out done");
    cfgLogicArray[1] <= 8'hff;
    macrocellOut[1] <= 8'h3c;
    macrocellOe[1] <= 8'h0f;
    repeat (2) @(posedge ref_clk);
    chk(64'({portPinOeN[1], portPinOut[1] & 8'h0f}), 64'hf00c);
    macrocellOe[1] <= 8'h00;
    repeat (2) @(posedge ref_clk);
    chk(64'(portPinOeN[1]), 64'hff);
    $display("test logic array done");
    wr(8'h70, 8'h80);
    rd(8'h70, 32'h80);
    // Last pass drops both selects with the write still up
    for (int s = 0; s < 4; s++) begin
      {peripheralSelectA, peripheralSelectB} <= 2'(s + 1);
      busWrite <= s != 2;
      repeat (2) @(posedge ref_clk);
      chk(64'({portPinOeN[5], portPinOut[5]}), s < 2 ? 64'h005a : 64'hff5a);
    end
    $display("test peripheral done");
    for (int j = 0; j < 3; j++) begin
      jtagEnable <= 3'(1 << j);
      repeat (2) @(posedge ref_clk);
      // Upper pins stay driven by the direction bits
      chk(64'(portPinOeN[4]), 64'h0f);
    end
    {cfgMuxBus, busDrive, jtagEnable} <= 5'h08;
    repeat (2) @(posedge ref_clk);
    chk(64'({portPinOeN[5], portPinOut[5], portPinOut[6]}), 64'h005aa5);
    repeat (2) @(posedge ref_clk);
    chk(64'(portFBusData), 64'h5a);
    busDrive <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(64'(portPinOeN[5]), 64'hff);
    repeat (3) @(posedge ref_clk);
    chk(64'(portFBusData), 64'h96);
    $display("test data port done");
    summarize();
  end
endmodule : tb_top
